// File: rtl/l2de_pkg.sv
// constants and types for the second-level cache data ecc error handler
package l2de_pkg;
   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int L2DE_DW    = 32;
   localparam int L2DE_EW    = 7;
   localparam int L2DE_SW    = 5;
   localparam int L2DE_NSTR  = 32;
   localparam int L2DE_NSUB  = 16;
   localparam int L2DE_SUBW  = 4;
   localparam int L2DE_BYTES = 4;
   // ------------------------------------------------------------------
   // register indexes
   // ------------------------------------------------------------------
   localparam logic [3:0] REG_ERR_EN  = 4'h0;
   localparam logic [3:0] REG_ERR_ST  = 4'h1;
   localparam logic [3:0] REG_ERR_AD  = 4'h2;
   localparam logic [3:0] REG_L2_CTL  = 4'h3;
   localparam logic [3:0] REG_MA_CTL  = 4'h4;
   // ------------------------------------------------------------------
   // enable register fields
   // ------------------------------------------------------------------
   localparam int EN_CEEN  = 0;
   localparam int EN_NCEEN = 1;
   localparam int EN_DBG   = 2;
   localparam logic [2:0] EN_RST  = 3'h0;
   // ------------------------------------------------------------------
   // status register fields
   // ------------------------------------------------------------------
   localparam int ST_MEU      = 31;
   localparam int ST_MEC      = 30;
   localparam int ST_RW       = 29;
   localparam int ST_MODA     = 28;
   localparam int ST_VCID     = 23;
   localparam int ST_ACC_CE   = 22;
   localparam int ST_ACC_UE   = 21;
   localparam int ST_WRITEBACK_CORRECTABLE = 20;
   localparam int ST_WB_UE    = 19;
   localparam int ST_DMA_CORRECTABLE = 18;
   localparam int ST_DMA_UE   = 17;
   localparam int ST_SCRUB_CORRECTABLE = 16;
   localparam int ST_SCRUB_UE = 15;
   localparam int ST_SYN      = 0;
   localparam logic [31:0] ST_W1C_MASK = 32'hC07F8000;
   localparam logic [31:0] ST_RW_MASK  = 32'h3F80007F;
   localparam logic [31:0] ST_UE_MASK  = 32'h002A8000;
   localparam logic [31:0] ST_FLG_MASK = 32'h007F8000;
   // ------------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------------
   localparam int CTL_STEER = 0;
   localparam int MA_INT    = 5;
   localparam int MA_STRAND = 0;
   localparam logic [4:0] CTL_RST = 5'h00;
   localparam logic [5:0] MA_RST  = 6'h00;
   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_LOAD, OP_IFETCH, OP_PREFETCH, OP_STORE, OP_ATOMIC,
      OP_MALOAD, OP_WBACK, OP_DMARD, OP_DMAWR, OP_SCRUB
   } l2de_op_t;
   typedef enum logic [1:0] {
      TRAP_ECC, TRAP_DATA_ERR, TRAP_DACC, TRAP_IACC
   } l2de_trap_t;
   typedef enum logic [1:0] {
      MA_IDLE, MA_WAIT_SYNC, MA_WAIT_LD
   } l2de_ma_st_t;
endpackage : l2de_pkg

// File: rtl/l2de_top.sv
// second-level cache data ecc check, correction, logging and trap steering
// Function
// - each 32-bit data subline carries a seven-bit single-correct double-detect code
// - stores writing under 32 bits are partial and need read-check-merge
// - load or fetch correctable: log, return corrected, trap if both enables
// - prefetch errors are logged only, never trapped; corrected data returned
// - partial store or atomic correctable: fix array, trap if both enables
// - modular load correctable: return corrected, tell modular unit if l2 enable
// - after modular completion, corrected trap goes to completion or sync strand
// - writeback correctable: correct outgoing data, trap steered strand if enabled
// - dma read correctable: return corrected data, trap steered strand if enabled
// - dma reads cover whole line; each bad subline is its own event
// - dma partial write correctable: correct line data, trap steered strand
// - only partial dma writes are checked; aligned writes skip checking
// - scrub correctable: rewrite corrected data and check bits, trap steered strand
// - load or fetch uncorrectable: log; with l2 enable log per strand, poison fill
// - both uncorrectable enables: precise load or fetch fault to requester
// - partial store uncorrectable: abandon merge, disrupting data trap if enabled
// - abandoned partial store or atomic still marks line dirty
// - a fill between partial store read and write may also set multiple flag
// - atomic uncorrectable: per-strand log, precise load fault, no update
// - modular load uncorrectable with l2 enable notifies modular unit to abort
// - abort with strand enable: data trap to completion strand or load fault
// - abort without strand enable: normal completion or clean sync load
// - errors always logged in status, address only on capture; enables gate traps, load or fetch poison, strand log and modular notes
// - status flags clear by writing one; reset leaves status untouched
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module l2de_top
   import l2de_pkg::*;
(
   input  wire logic                  i_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic [3:0]            i_reg_addr,
   input  wire logic [31:0]           i_reg_wdata,
   input  wire logic                  i_reg_wr,
   input  wire logic                  i_reg_rd,
   output logic      [31:0]           o_reg_rdata,
   input  wire logic                  i_chk_valid,
   input  wire logic [3:0]            i_chk_op,
   input  wire logic [L2DE_SW-1:0]    i_chk_strand,
   input  wire logic [L2DE_SUBW-1:0]  i_chk_sub,
   input  wire logic [31:0]           i_chk_addr,
   input  wire logic [L2DE_DW-1:0]    i_chk_data,
   input  wire logic [L2DE_EW-1:0]    i_chk_ecc,
   input  wire logic [L2DE_BYTES-1:0] i_chk_wmask,
   input  wire logic [L2DE_DW-1:0]    i_chk_wdata,
   input  wire logic                  i_fill_gap,
   input  wire logic [L2DE_NSTR-1:0]  i_strand_ceen,
   input  wire logic [L2DE_NSTR-1:0]  i_strand_nceen,
   input  wire logic                  i_ma_done,
   input  wire logic                  i_ma_ld_valid,
   input  wire logic                  i_ma_ld_sync,
   input  wire logic [L2DE_SW-1:0]    i_ma_ld_strand,
   output logic                       o_rsp_valid,
   output logic      [L2DE_DW-1:0]    o_rsp_data,
   output logic                       o_rsp_poison,
   output logic      [L2DE_SUBW-1:0]  o_rsp_sub,
   output logic                       o_arr_wr,
   output logic      [L2DE_DW-1:0]    o_arr_data,
   output logic      [L2DE_EW-1:0]    o_arr_ecc,
   output logic                       o_mark_dirty,
   output logic                       o_strand_log,
   output logic                       o_ma_ce,
   output logic                       o_ma_ue,
   output logic                       o_ma_cpl_irq,
   output logic                       o_debug_trig,
   output logic                       o_trap_valid,
   output logic      [L2DE_SW-1:0]    o_trap_strand,
   output logic      [1:0]            o_trap_type,
   output logic                       o_trap_precise
);
   // ------------------------------------------------------------------
   // code generation and single bit correction
   // ------------------------------------------------------------------
   function automatic logic [6:0] ecc_gen(input logic [31:0] d);
      logic [5:0] c;
      int         k;
      c = 6'h00;
      k = 0;
      for (int p = 1; p < 39; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (d[k]) c = c ^ p[5:0];
            k = k + 1;
         end
      end
      return {(^d) ^ (^c), c};
   endfunction : ecc_gen

   function automatic logic [31:0] ecc_fix(input logic [31:0] d, input logic [5:0] s);
      logic [31:0] r;
      int          k;
      r = d;
      k = 0;
      for (int p = 1; p < 39; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (p[5:0] == s) r[k] = ~d[k];
            k = k + 1;
         end
      end
      return r;
   endfunction : ecc_fix

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [2:0]          err_en;
   logic [31:0]         status;
   logic [31:0]         err_addr;
   logic [4:0]          l2_control_register;
   logic [5:0]          modarith_control_register;
   logic                pend_v;
   logic [L2DE_SW-1:0]  pend_strand;
   logic [1:0]          pend_type;
   logic                pend_precise;
   logic                ma_ce_seen;
   logic                ma_ue_seen;
   l2de_ma_st_t         ma_st;

   // ------------------------------------------------------------------
   // operation decode
   // ------------------------------------------------------------------
   wire l2de_op_t op       = l2de_op_t'(i_chk_op);
   wire is_ld              = (op == OP_LOAD);
   wire is_if              = (op == OP_IFETCH);
   wire is_pf              = (op == OP_PREFETCH);
   wire is_st              = (op == OP_STORE);
   wire is_at              = (op == OP_ATOMIC);
   wire is_ma              = (op == OP_MALOAD);
   wire is_wb              = (op == OP_WBACK);
   wire is_dr              = (op == OP_DMARD);
   wire is_dw              = (op == OP_DMAWR);
   wire is_sc              = (op == OP_SCRUB);
   wire is_acc             = is_ld | is_if | is_pf | is_st | is_at | is_ma;
   wire is_steered         = is_wb | is_dr | is_dw | is_sc;
   wire is_wr_op           = is_st | is_at | is_dw;
   wire is_partial         = (i_chk_wmask != 4'hF);
   wire chk_en             = i_chk_valid & (((is_st | is_dw) & is_partial) |
                                            ~(is_st | is_dw));

   // ------------------------------------------------------------------
   // syndrome and correction
   // ------------------------------------------------------------------
   // subline code check
   wire [6:0]  calc_ecc    = ecc_gen(i_chk_data);
   wire [5:0]  syn         = calc_ecc[5:0] ^ i_chk_ecc[5:0];
   wire        par_err     = ^{i_chk_data, i_chk_ecc};
   wire        ce          = chk_en & par_err;
   wire        ue          = chk_en & ~par_err & (syn != 6'h00);
   wire [31:0] cor_data    = ce ? ecc_fix(i_chk_data, syn) : i_chk_data;
   logic [31:0] merge_data;

   genvar b;
   generate
      for (b = 0; b < L2DE_BYTES; b++) begin : g_merge
         assign merge_data[8*b +: 8] = i_chk_wmask[b] ? i_chk_wdata[8*b +: 8]
                                                      : cor_data[8*b +: 8];
      end
   endgenerate

   // ------------------------------------------------------------------
   // array update and response
   // ------------------------------------------------------------------
   // stores, atomics and dma writes update array unless uncorrectable; scrub only when correctable
   wire        arr_we      = i_chk_valid & ((is_wr_op & ~ue) | (is_sc & ce));
   wire [31:0] arr_d       = is_at ? i_chk_wdata : is_sc ? cor_data : merge_data;
   wire        dirty       = i_chk_valid & is_wr_op;
   wire        rsp_v       = i_chk_valid & ~is_st & ~is_dw & ~is_sc;
   wire        l2c         = err_en[EN_CEEN];
   wire        l2u         = err_en[EN_NCEEN];
   // load or fetch poison fill only with l2 enable; other uncorrectable reads always poison
   wire        poison      = ue & ((is_ld | is_if) ? l2u : 1'b1);
   wire        slog        = ue & l2u & (is_ld | is_if | is_at);
   wire        ma_ce_n     = ce & is_ma & l2c;
   wire        ma_ue_n     = ue & is_ma & l2u;

   // ------------------------------------------------------------------
   // trap decision
   // ------------------------------------------------------------------
   wire [4:0]  steer       = l2_control_register;
   wire [4:0]  tgt         = is_steered ? steer : i_chk_strand;
   wire        s_ce        = i_strand_ceen[tgt];
   wire        s_ue        = i_strand_nceen[tgt];
   // writeback trap needs steered strand enable
   wire        ce_trap     = ce & l2c & s_ce & ~is_pf & ~is_ma;
   wire        ue_trap     = ue & l2u & s_ue & ~is_pf & ~is_ma;
   wire        ue_precise  = is_ld | is_if | is_at;
   wire [1:0]  ue_type     = is_if ? TRAP_IACC : (is_ld | is_at) ? TRAP_DACC
                                                               : TRAP_DATA_ERR;
   wire        chk_trap    = ce_trap | ue_trap;
   wire [1:0]  chk_type    = ue_trap ? ue_type : TRAP_ECC;
   wire        chk_prec    = ue_trap & ue_precise;

   // ------------------------------------------------------------------
   // status logging
   // ------------------------------------------------------------------
   wire        st_wr       = i_reg_wr & (i_reg_addr == REG_ERR_ST);
   wire        any_flag    = |(status & ST_FLG_MASK);
   wire        any_ue      = |(status & ST_UE_MASK);
   wire        capture     = (ce & ~any_flag) | (ue & ~any_ue);
   wire        set_mec     = ce & any_flag;
   wire        set_meu     = ue & (any_ue | (is_st & i_fill_gap));
   wire [4:0]  ev_idx      = is_acc ? (ue ? 5'(ST_ACC_UE) : 5'(ST_ACC_CE)) :
                             is_wb  ? (ue ? 5'(ST_WB_UE)
                                          : 5'(ST_WRITEBACK_CORRECTABLE)) :
                             is_sc  ? (ue ? 5'(ST_SCRUB_UE)
                                          : 5'(ST_SCRUB_CORRECTABLE)) :
                                      (ue ? 5'(ST_DMA_UE)
                                          : 5'(ST_DMA_CORRECTABLE));
   wire [31:0] ev_flag     = capture ? (32'h00000001 << ev_idx) : 32'h00000000;
   wire [31:0] ev_mult     = ({31'h0, set_mec} << ST_MEC) |
                             ({31'h0, set_meu} << ST_MEU);
   wire [31:0] ev_info     = ({31'h0, is_wr_op} << ST_RW) |
                             ({31'h0, is_ma} << ST_MODA) |
                             ({27'h0, i_chk_strand} << ST_VCID) |
                             {25'h0, par_err, syn};
   // write one to clear, rw fields plain
   wire [31:0] st_base     = st_wr ? ((status & ST_W1C_MASK & ~i_reg_wdata) |
                                      (i_reg_wdata & ST_RW_MASK)) : status;
   wire [31:0] next_status = capture ? ((st_base & ~ST_RW_MASK) | ev_info |
                                        ev_flag | ev_mult)
                                     : (st_base | ev_mult);

   // status and address hold across reset
   always_ff @(posedge i_clk) begin
      status <= next_status;
      if (capture) err_addr <= i_chk_addr;
   end

   // ------------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------------
   wire [31:0] rd_mux      = (i_reg_addr == REG_ERR_EN) ? {29'h0, err_en} :
                             (i_reg_addr == REG_ERR_ST) ? status :
                             (i_reg_addr == REG_ERR_AD) ? err_addr :
                             (i_reg_addr == REG_L2_CTL) ? {27'h0, l2_control_register} :
                             (i_reg_addr == REG_MA_CTL) ?
                                {26'h0, modarith_control_register} : 32'h00000000;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         err_en                    <= EN_RST;
         l2_control_register       <= CTL_RST;
         modarith_control_register <= MA_RST;
         o_reg_rdata               <= 32'h00000000;
      end else begin
         if (i_reg_wr && i_reg_addr == REG_ERR_EN) err_en <= i_reg_wdata[2:0];
         if (i_reg_wr && i_reg_addr == REG_L2_CTL) l2_control_register <= i_reg_wdata[4:0];
         if (i_reg_wr && i_reg_addr == REG_MA_CTL)
            modarith_control_register <= i_reg_wdata[5:0];
         o_reg_rdata <= i_reg_rd ? rd_mux : 32'h00000000;
      end
   end

   // ------------------------------------------------------------------
   // modular unit follow-up
   // ------------------------------------------------------------------
   wire [4:0]  cpl         = modarith_control_register[4:0];
   wire        ma_int      = modarith_control_register[MA_INT];
   logic       next_pv;
   logic [4:0] next_ps;
   logic [1:0] next_pt;
   logic       next_pp;
   logic       next_irq;
   l2de_ma_st_t next_ma_st;

   always_comb begin
      next_pv    = 1'b0;
      next_ps    = cpl;
      next_pt    = TRAP_ECC;
      next_pp    = 1'b0;
      next_irq   = 1'b0;
      next_ma_st = ma_st;
      case (ma_st)
         MA_IDLE: begin
            if (i_ma_done) begin
               if (ma_ue_seen) begin
                  if (ma_int) begin
                     next_pv  = i_strand_nceen[cpl];
                     next_pt  = TRAP_DATA_ERR;
                     next_irq = ~i_strand_nceen[cpl];
                  end else begin
                     next_ma_st = MA_WAIT_LD;
                  end
               end else if (ma_ce_seen) begin
                  if (ma_int) begin
                     next_pv  = i_strand_ceen[cpl];
                     next_irq = 1'b1;
                  end else begin
                     next_ma_st = MA_WAIT_SYNC;
                  end
               end else begin
                  next_irq = ma_int;
               end
            end
         end
         MA_WAIT_LD: begin
            if (i_ma_ld_valid) begin
               next_pv    = i_strand_nceen[i_ma_ld_strand];
               next_ps    = i_ma_ld_strand;
               next_pt    = TRAP_DACC;
               next_pp    = 1'b1;
               next_ma_st = MA_IDLE;
            end
         end
         MA_WAIT_SYNC: begin
            if (i_ma_ld_valid && i_ma_ld_sync) begin
               next_pv    = i_strand_ceen[i_ma_ld_strand];
               next_ps    = i_ma_ld_strand;
               next_ma_st = MA_IDLE;
            end
         end
         default: next_ma_st = MA_IDLE;
      endcase
   end

   wire ma_clr = i_ma_done & (ma_st == MA_IDLE);

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ma_st      <= MA_IDLE;
         ma_ce_seen <= 1'b0;
         ma_ue_seen <= 1'b0;
      end else begin
         ma_st      <= next_ma_st;
         ma_ce_seen <= ma_ce_n | (ma_ce_seen & ~ma_clr);
         ma_ue_seen <= ma_ue_n | (ma_ue_seen & ~ma_clr);
      end
   end

   // ------------------------------------------------------------------
   // trap issue, check path first, pending modular trap second
   // ------------------------------------------------------------------
   wire pend_go = pend_v & ~chk_trap;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pend_v       <= 1'b0;
         pend_strand  <= 5'h00;
         pend_type    <= 2'h0;
         pend_precise <= 1'b0;
      end else if (next_pv) begin
         pend_v       <= 1'b1;
         pend_strand  <= next_ps;
         pend_type    <= next_pt;
         pend_precise <= next_pp;
      end else if (pend_go) begin
         pend_v       <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_trap_valid   <= 1'b0;
         o_trap_strand  <= 5'h00;
         o_trap_type    <= 2'h0;
         o_trap_precise <= 1'b0;
      end else begin
         o_trap_valid   <= chk_trap | pend_v;
         o_trap_strand  <= chk_trap ? tgt : pend_strand;
         o_trap_type    <= chk_trap ? chk_type : pend_type;
         o_trap_precise <= chk_trap ? chk_prec : pend_precise;
      end
   end

   // ------------------------------------------------------------------
   // data path outputs
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rsp_valid  <= 1'b0;
         o_rsp_data   <= 32'h00000000;
         o_rsp_poison <= 1'b0;
         o_rsp_sub    <= 4'h0;
         o_arr_wr     <= 1'b0;
         o_arr_data   <= 32'h00000000;
         o_arr_ecc    <= 7'h00;
         o_mark_dirty <= 1'b0;
         o_strand_log <= 1'b0;
         o_ma_ce      <= 1'b0;
         o_ma_ue      <= 1'b0;
         o_ma_cpl_irq <= 1'b0;
         o_debug_trig <= 1'b0;
      end else begin
         o_rsp_valid  <= rsp_v;
         o_rsp_data   <= cor_data;
         o_rsp_poison <= rsp_v & poison;
         o_rsp_sub    <= i_chk_sub;
         o_arr_wr     <= arr_we;
         o_arr_data   <= arr_d;
         o_arr_ecc    <= ecc_gen(arr_d);
         o_mark_dirty <= dirty;
         o_strand_log <= slog;
         o_ma_ce      <= ma_ce_n;
         o_ma_ue      <= ma_ue_n;
         o_ma_cpl_irq <= next_irq;
         o_debug_trig <= ue & err_en[EN_DBG];
      end
   end
endmodule : l2de_top

// File: sim/l2de_modarith_model.sv
// behavioural modular-arithmetic unit answering the handler
`timescale 1ns/100ps
module l2de_modarith_model #(parameter int DONE_LAT = 3) (
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_ma_ce,
   input  wire logic i_ma_ue,
   output logic      o_done
);
   int cnt;
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt    <= 0;
         o_done <= 1'b0;
      end else begin
         cnt    <= i_ma_ue ? 1 : i_ma_ce ? DONE_LAT : (cnt > 0 ? cnt - 1 : 0);
         o_done <= (cnt == 1);
      end
   end
endmodule : l2de_modarith_model

// File: sim/l2de_top_checker.sv
// port assertions for the l2 data ecc handler
`timescale 1ns/100ps
module l2de_top_checker
   import l2de_pkg::*;
(
   input wire logic       i_clk, i_sys_rst, i_chk_valid, o_rsp_valid, o_rsp_poison,
   input wire logic       o_arr_wr, o_mark_dirty, o_ma_ce, o_ma_ue, o_debug_trig,
   input wire logic [3:0] i_chk_op, i_chk_sub, i_chk_wmask, o_rsp_sub
);
   wire logic [3:0] op = i_chk_valid ? i_chk_op : 4'hF;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_pf; op == OP_PREFETCH |=> o_rsp_valid && !o_rsp_poison; endproperty
   a_pf: assert property (p_pf) else $error("prefetch answer");
   property p_sub; op == OP_DMARD |=> o_rsp_valid && o_rsp_sub == $past(i_chk_sub); endproperty
   a_sub: assert property (p_sub) else $error("dma subline");
   property p_dirty; op inside {OP_STORE, OP_ATOMIC, OP_DMAWR} |=> o_mark_dirty; endproperty
   a_dirty: assert property (p_dirty) else $error("dirty mark");
   property p_full; op == OP_DMAWR && i_chk_wmask == 4'hF |=> !o_debug_trig; endproperty
   a_full: assert property (p_full) else $error("aligned dma checked");
   property p_psn; o_rsp_poison |-> $past(op) inside {OP_LOAD, OP_IFETCH, OP_PREFETCH,
      OP_ATOMIC, OP_MALOAD, OP_DMARD}; endproperty
   a_psn: assert property (p_psn) else $error("poison source");
   property p_arr; o_arr_wr |-> $past(op) inside {OP_STORE, OP_ATOMIC, OP_DMAWR, OP_SCRUB}; endproperty
   a_arr: assert property (p_arr) else $error("array write source");
   property p_ue; o_ma_ue |-> $past(op) == OP_MALOAD; endproperty
   a_ue: assert property (p_ue) else $error("modular abort source");
   property p_ce; o_ma_ce |-> $past(op) == OP_MALOAD; endproperty
   a_ce: assert property (p_ce) else $error("modular note source");
endmodule : l2de_top_checker
bind l2de_top l2de_top_checker l2de_top_checker_i (.*);

// File: sim/l2de_top_test.sv
// self-checking bench for the l2 data ecc error handler
`timescale 1ns/100ps
module l2de_top_test
   import l2de_pkg::*;
;
   logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_chk_valid = 1'b0;
   logic        i_ma_done, o_rsp_valid, o_rsp_poison, o_arr_wr, o_mark_dirty, o_strand_log, o_ma_ce;
   logic        o_ma_ue, o_ma_cpl_irq, o_debug_trig, o_trap_valid, o_trap_precise;
   logic [1:0]  o_trap_type;
   logic [3:0]  i_reg_addr = 4'h0, i_chk_op = 4'h0, i_chk_sub = 4'h0, i_chk_wmask = 4'h0, o_rsp_sub;
   logic [4:0]  i_chk_strand = 5'h00, o_trap_strand;
   logic [6:0]  i_chk_ecc = 7'h00, o_arr_ecc;
   logic [31:0] i_reg_wdata = 32'h0, i_chk_addr = 32'h0, i_chk_data = 32'h0, i_chk_wdata = 32'h0;
   logic [31:0] i_strand_ceen = 32'hFFFFFFFF, i_strand_nceen = 32'hFFFFFFFF, o_reg_rdata;
   logic [31:0] o_rsp_data, o_arr_data;
   int          errors = 0, cmp_count = 0;
   localparam logic [3:0] UE_OP [4] = '{OP_LOAD, OP_IFETCH, OP_ATOMIC, OP_STORE};
   localparam logic [5:0] UE_EXP [4] = '{6'h35, 6'h3D, 6'h35, 6'h28};
   l2de_top l2de_top_i (.*, .i_fill_gap(1'b0), .i_ma_ld_valid(1'b0), .i_ma_ld_sync(1'b0),
                        .i_ma_ld_strand(5'h00));
   l2de_modarith_model l2de_modarith_model_i (.i_clk, .i_sys_rst, .i_ma_ce(o_ma_ce),
                                              .i_ma_ue(o_ma_ue), .o_done(i_ma_done));
   always #25 i_clk = ~i_clk;
   initial begin
      #100000;
      errors++;
      results();
   end
   task automatic cmp(input logic [39:0] seen, input logic [39:0] want);
      cmp_count++;
      if (seen !== want) begin
         errors++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask : cmp
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_reg_wr    <= w;
      i_reg_rd    <= ~w;
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
      i_reg_rd <= 1'b0;
      #1;
   endtask : acc
   task automatic chk(input logic [3:0] op, input logic [31:0] d, input logic [6:0] e,
                      input logic [3:0] wm);
      @(posedge i_clk);
      i_chk_valid  <= 1'b1;
      i_chk_op     <= op;
      i_chk_sub    <= op;
      i_chk_strand <= {1'b1, op};
      i_chk_addr   <= {28'h0, op};
      i_chk_data   <= d;
      i_chk_ecc    <= e;
      i_chk_wmask  <= wm;
      i_chk_wdata  <= {op, 20'h0, 8'hC3};
      @(posedge i_clk);
      i_chk_valid <= 1'b0;
      #1;
   endtask : chk
   task automatic ma(input logic [31:0] d, input logic [7:0] want);
      chk(OP_MALOAD, d, 7'h00, 4'h0);
      for (int k = 0; k < 12 && o_trap_valid !== 1'b1; k++) begin
         @(posedge i_clk);
         #1;
      end
      cmp({o_trap_strand, o_trap_type, o_trap_precise}, want);
   endtask : ma
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   initial begin
      logic [3:0] op;
      logic       sa;
      logic [4:0] st;
      repeat (4) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      acc(1'b1, REG_ERR_EN, 32'h7);
      acc(1'b1, REG_L2_CTL, 32'h9);
      acc(1'b1, REG_MA_CTL, 32'h27);
      for (int i = 0; i < 10; i++) begin
         op = i[3:0];
         sa = op inside {OP_STORE, OP_ATOMIC, OP_DMAWR, OP_SCRUB};
         st = (op > OP_MALOAD) ? 5'h09 : {1'b1, op};
         if (op == OP_MALOAD) ma(32'h1, 8'h38);
         else begin
            chk(op, {31'h0, op != OP_SCRUB}, {6'h0, op == OP_SCRUB}, 4'h1);
            cmp(o_trap_valid, op != OP_PREFETCH);
            if (o_trap_valid === 1'b1) cmp({o_trap_strand, o_trap_type}, {st, TRAP_ECC});
            cmp({o_arr_wr, op == OP_SCRUB ? o_arr_ecc : 7'h0, o_arr_wr ? o_arr_data : 32'h0},
                {sa, 7'h0, op == OP_ATOMIC ? 32'h400000C3 : (sa && op != OP_SCRUB) ? 32'hC3 : 32'h0});
            cmp({o_rsp_valid, o_rsp_valid ? o_rsp_data : 32'h0}, {!sa || op == OP_ATOMIC, 32'h0});
         end
      end
      chk(OP_DMAWR, 32'h3, 7'h00, 4'hF);
      cmp({o_trap_valid, o_debug_trig}, 2'b00);
      $display("correctable sweep done");
      acc(1'b1, REG_ERR_ST, 32'hFFFFFFFF);
      i_strand_ceen <= 32'hFFFFFDFF;
      chk(OP_WBACK, 32'h1, 7'h00, 4'h1);
      cmp(o_trap_valid, 1'b0);
      acc(1'b0, REG_ERR_ST, 32'h0);
      cmp(o_reg_rdata[ST_WRITEBACK_CORRECTABLE], 1'b1);
      acc(1'b1, REG_ERR_ST, 32'h00100000);
      acc(1'b0, REG_ERR_ST, 32'h0);
      cmp(o_reg_rdata[ST_WRITEBACK_CORRECTABLE], 1'b0);
      i_strand_ceen <= 32'hFFFFFFFF;
      $display("gating and status done");
      for (int j = 0; j < 4; j++) begin
         chk(UE_OP[j], 32'h3, 7'h00, 4'h1);
         cmp({o_trap_valid, o_trap_type, o_trap_precise, o_arr_wr, o_rsp_poison}, UE_EXP[j]);
         cmp({o_strand_log, o_debug_trig}, {j < 3, 1'b1});
      end
      ma(32'h3, 8'h3A);
      $display("uncorrectable sweep done");
      results();
   end
endmodule : l2de_top_test
